// ===== hw/apms_defines.svh
// edge counts, timing figures and saturation limits for the power-mode sequencer
`ifndef APMS_DEFINES_SVH
`define APMS_DEFINES_SVH

// serial-clock falling-edge thresholds within one select-low frame
`define APMS_GLITCH_EDGES 6'h02
`define APMS_KEEP_EDGES 6'h0a
`define APMS_RESULT_EDGES 6'h0e
`define APMS_HALF_EDGES 6'h10
`define APMS_RELEASE_EDGES 6'h20
`define APMS_CNT_SAT 6'h21
`define APMS_FIRST_EDGE 6'h01

// bit positions inside one 16-edge half frame
`define APMS_FIRST_DATA_POS 4'h2
`define APMS_LAST_DATA_POS 4'hd

// timing figures, in nanoseconds
`define APMS_SYS_PERIOD_NS 25
`define APMS_PART_WAKE_NS 1000
`define APMS_FULL_WAKE_NS 1500000

`endif

// ===== hw/apms_pkg.sv
// types and helper functions for the power-mode sequencer
package apms_pkg;

    // power mode held between frames
    typedef enum logic [1:0] {
        APMS_NORMAL,
        APMS_PARTIAL_DOWN,
        APMS_FULL_DOWN
    } apms_mode_t;

    // binary to gray, so the edge count crosses clocks safely
    function automatic logic [5:0] apms_bin2gray(input logic [5:0] b);
        return b ^ (b >> 1);
    endfunction

    // gray back to binary in the system domain
    function automatic logic [5:0] apms_gray2bin(input logic [5:0] g);
        logic [5:0] b;
        b[5] = g[5];
        for (int i = 4; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// ===== hw/apms_sequencer.sv
// power-mode sequencer and serial result shifter of a dual sampling converter
`timescale 1ns/1ps

`include "apms_defines.svh"

module apms_sequencer
    import apms_pkg::*;
#(
    parameter int RES_W = 12,
    parameter int TIMER_W = 16,
    parameter int FULL_WAKE_CYC =
        (`APMS_FULL_WAKE_NS + `APMS_SYS_PERIOD_NS - 1) / `APMS_SYS_PERIOD_NS
) (
    // system clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // serial link from the host
    input wire logic i_converter_serial_clock,
    input wire logic i_select_n,
    // conversion results from the two converter cores
    input wire logic [RES_W-1:0] i_conv_result_a,
    input wire logic [RES_W-1:0] i_conv_result_b,
    // result line a, two signals of a three-state pin
    output logic o_result_line_a,
    output logic o_result_line_a_oe,
    // result line b
    output logic o_result_line_b,
    output logic o_result_line_b_oe,
    // power control toward the analog section
    output logic [1:0] o_power_mode,
    output logic o_analog_on,
    output logic o_reference_on,
    output logic o_powered_up,
    output logic o_conversion_aborted
);

    // partial wake is short, so a fixed count is enough
    localparam int PART_WAKE_CYC =
        (`APMS_PART_WAKE_NS + `APMS_SYS_PERIOD_NS - 1) / `APMS_SYS_PERIOD_NS;

    // refuse shapes the shifter or timer cannot serve
    if (RES_W != 12) begin : g_bad_res
        $error("result width must be 12 to fit a 16-edge half frame");
    end
    if (FULL_WAKE_CYC < 1 || FULL_WAKE_CYC >= (1 << TIMER_W)) begin : g_bad_full
        $error("full wake count does not fit the wake timer");
    end
    if (PART_WAKE_CYC >= (1 << TIMER_W)) begin : g_bad_part
        $error("partial wake count does not fit the wake timer");
    end

    // bit shown on a line after n falling edges; own then other word
    function automatic logic result_bit(
        input logic [5:0] n,
        input logic [RES_W-1:0] own,
        input logic [RES_W-1:0] other
    );
        logic [3:0] pos;
        logic [RES_W-1:0] word;
        pos = n[3:0];
        word = (n < `APMS_HALF_EDGES) ? own : other;
        result_bit = 1'b0;
        if (pos >= `APMS_FIRST_DATA_POS && pos <= `APMS_LAST_DATA_POS) begin
            result_bit = word[4'(`APMS_LAST_DATA_POS - pos)];
        end
    endfunction

    // ------------------------------------------------------------------
    // link domain, clocked on serial-clock falling edges
    // ------------------------------------------------------------------

    // high from select rise until the first falling edge of the next frame
    logic frame_new;
    // falling edges seen in this frame, saturating
    logic [5:0] edge_cnt;
    logic [5:0] next_edge_cnt;
    // results held for the whole frame
    logic [RES_W-1:0] cap_a;
    logic [RES_W-1:0] cap_b;
    logic [RES_W-1:0] next_cap_a;
    logic [RES_W-1:0] next_cap_b;
    // shifted bits, one per line
    logic bit_a;
    logic bit_b;
    logic next_bit_a;
    logic next_bit_b;
    // gray copy of the edge count for the system domain
    logic [5:0] cnt_gray;
    logic [5:0] next_cnt_gray;

    // select high forces the frame marker with a constant; the serial clock
    // may be stopped between frames, so no clock edge can be relied on here
    always_ff @(negedge i_converter_serial_clock or posedge i_select_n) begin
        if (i_select_n) begin
            frame_new <= 1'b1;
        end else begin
            frame_new <= 1'b0;
        end
    end

    // next count, captured words and shifted bits
    always_comb begin
        next_edge_cnt = edge_cnt;
        next_cap_a = cap_a;
        next_cap_b = cap_b;
        // idle clocks with select high change nothing
        if (!i_select_n) begin
            if (frame_new) begin
                // an edge with select still high is not counted
                next_edge_cnt = `APMS_FIRST_EDGE;
                next_cap_a = i_conv_result_a;
                next_cap_b = i_conv_result_b;
            end else if (edge_cnt < `APMS_CNT_SAT) begin
                next_edge_cnt = edge_cnt + `APMS_FIRST_EDGE;
            end
        end
        // a line takes its own word first, then the other channel's
        next_bit_a = result_bit(next_edge_cnt, next_cap_a, next_cap_b);
        next_bit_b = result_bit(next_edge_cnt, next_cap_b, next_cap_a);
        next_cnt_gray = apms_bin2gray(next_edge_cnt);
    end

    // link registers, no reset: every frame reloads them on its first edge
    always_ff @(negedge i_converter_serial_clock) begin
        edge_cnt <= next_edge_cnt;
        cap_a <= next_cap_a;
        cap_b <= next_cap_b;
        bit_a <= next_bit_a;
        bit_b <= next_bit_b;
        cnt_gray <= next_cnt_gray;
    end

    // leading zero stands from select fall until the first edge
    assign o_result_line_a = frame_new ? 1'b0 : bit_a;
    assign o_result_line_b = frame_new ? 1'b0 : bit_b;

    // drive while select is low and fewer than 32 edges have passed;
    // select rise releases at once, also on an aborted frame
    assign o_result_line_a_oe = !i_select_n &&
        (frame_new || edge_cnt < `APMS_RELEASE_EDGES);
    assign o_result_line_b_oe = !i_select_n &&
        (frame_new || edge_cnt < `APMS_RELEASE_EDGES);

    // ------------------------------------------------------------------
    // system domain
    // ------------------------------------------------------------------

    // select and gray count pass two flops before any logic reads them
    logic sel_meta;
    logic sel_sync;
    logic sel_prev;
    logic [5:0] gray_meta;
    logic [5:0] gray_sync;
    // previous synced count, to see whether the count moved
    logic [5:0] gray_prev;

    // synchronisers; first stages are read only by second stages
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sel_meta <= 1'b1;
            sel_sync <= 1'b1;
            sel_prev <= 1'b1;
            gray_meta <= '0;
            gray_sync <= '0;
            gray_prev <= '0;
        end else begin
            sel_meta <= i_select_n;
            sel_sync <= sel_meta;
            sel_prev <= sel_sync;
            gray_meta <= cnt_gray;
            gray_sync <= gray_meta;
            gray_prev <= gray_sync;
        end
    end

    // select edges as seen in this domain
    logic sel_fall;
    logic sel_rise;
    // edge count of the frame that is closing
    logic [5:0] edges;
    // a frame with no serial edge leaves the old count standing, so only a
    // count that moved since the last decision belongs to this frame
    logic seen_move;
    logic next_seen_move;
    logic count_moved;

    assign sel_fall = sel_prev && !sel_sync;
    assign sel_rise = !sel_prev && sel_sync;
    // the last edge lands before select rises, so the count is settled
    // by the time the synchronised rise arrives
    assign count_moved = seen_move || (gray_sync != gray_prev);
    assign edges = count_moved ? apms_gray2bin(gray_sync) : '0;

    // mode, wake timer and registered power outputs
    apms_mode_t mode;
    apms_mode_t next_mode;
    logic [TIMER_W-1:0] wake_timer;
    logic [TIMER_W-1:0] next_wake_timer;
    logic analog_on;
    logic next_analog_on;
    logic reference_on;
    logic next_reference_on;
    logic powered_up;
    logic next_powered_up;
    logic aborted;
    logic next_aborted;

    // mode decision at select rise, wake timing from select fall
    always_comb begin
        next_mode = mode;
        next_wake_timer = wake_timer;
        next_aborted = 1'b0;
        // remember any count movement until the frame is decided
        next_seen_move = count_moved;
        // wake timer runs down on its own
        if (wake_timer != '0) begin
            next_wake_timer = wake_timer - 1'b1;
        end
        if (sel_fall) begin
            // power-up starts at select fall, from either down mode
            case (mode)
                APMS_PARTIAL_DOWN: next_wake_timer = TIMER_W'(PART_WAKE_CYC);
                APMS_FULL_DOWN: next_wake_timer = TIMER_W'(FULL_WAKE_CYC);
                default: next_wake_timer = next_wake_timer;
            endcase
        end else if (sel_rise) begin
            // the next frame starts from an unmoved count
            next_seen_move = 1'b0;
            if (edges < `APMS_GLITCH_EDGES) begin
                // glitch: keep the mode; a started power-up is dropped
                next_mode = mode;
                if (mode != APMS_NORMAL) begin
                    next_wake_timer = '0;
                end
            end else if (edges < `APMS_KEEP_EDGES) begin
                // interrupted inside the power-down window
                next_aborted = 1'b1;
                next_wake_timer = '0;
                case (mode)
                    APMS_NORMAL: next_mode = APMS_PARTIAL_DOWN;
                    default: next_mode = APMS_FULL_DOWN;
                endcase
            end else begin
                // held past the tenth edge: fully powered from here on;
                // the wake timer keeps running from select fall
                next_mode = APMS_NORMAL;
                next_aborted = (edges < `APMS_RESULT_EDGES);
            end
        end
        // analog section is on in normal mode and while a wake frame is low
        next_analog_on = (next_mode == APMS_NORMAL) || !sel_sync;
        // reference stays on except in full down outside a wake frame
        next_reference_on = (next_mode != APMS_FULL_DOWN) || !sel_sync;
        // results are valid once normal and the wake time has passed
        next_powered_up = (next_mode == APMS_NORMAL) && (next_wake_timer == '0);
    end

    // power-on mode is undefined; normal is the defined reset choice
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            mode <= APMS_NORMAL;
            wake_timer <= '0;
            analog_on <= 1'b1;
            reference_on <= 1'b1;
            powered_up <= 1'b1;
            aborted <= 1'b0;
            seen_move <= 1'b0;
        end else begin
            mode <= next_mode;
            wake_timer <= next_wake_timer;
            analog_on <= next_analog_on;
            reference_on <= next_reference_on;
            powered_up <= next_powered_up;
            aborted <= next_aborted;
            seen_move <= next_seen_move;
        end
    end

    // status toward the rest of the chip
    assign o_power_mode = mode;
    assign o_analog_on = analog_on;
    assign o_reference_on = reference_on;
    assign o_powered_up = powered_up;
    assign o_conversion_aborted = aborted;

endmodule

// ===== test/apms_host_model.sv
// host model: drives select and the serial clock, captures both result lines
`timescale 1ns/1ps
module apms_host_model (
    // serial link toward the converter
    output logic o_converter_serial_clock,
    output logic o_select_n,
    // result lines back from the converter
    input wire logic i_result_line_a,
    input wire logic i_result_line_a_oe,
    input wire logic i_result_line_b,
    input wire logic i_result_line_b_oe
);
    logic [40:0] dat_a, dat_b, oe_a, oe_b; // captured per edge position
    // clock idles high, so it stands still between frames
    initial begin
        o_converter_serial_clock = 1'b1;
        o_select_n = 1'b1;
    end
    // one frame of n falling edges; a short n ends early, no need to finish
    task automatic run_frame(input int n);
        o_select_n = 1'b0;
        #7.5;
        for (int k = 1; k <= n; k++) begin
            o_converter_serial_clock = 1'b0;
            #7.5;
            // sample half a period after the shift, data is settled here
            o_converter_serial_clock = 1'b1;
            dat_a[k] = i_result_line_a;
            dat_b[k] = i_result_line_b;
            oe_a[k] = i_result_line_a_oe;
            oe_b[k] = i_result_line_b_oe;
            #7.5;
        end
        o_select_n = 1'b1;
        // quiet time, also lets the system side see select high
        #300;
    endtask
endmodule

// ===== test/apms_seq_properties.sv
// power-mode checker bound to the sequencer top
`timescale 1ns/1ps
module apms_seq_properties (
    // system clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // watched ports
    input wire logic i_select_n,
    input wire logic o_result_line_a_oe,
    input wire logic o_result_line_b_oe,
    input wire logic [1:0] o_power_mode,
    input wire logic o_analog_on,
    input wire logic o_reference_on,
    input wire logic o_powered_up,
    input wire logic o_conversion_aborted
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // select high long enough for the synced copy to settle
    sequence s_idle;
        i_select_n [*6];
    endsequence
    // select held low past the synchroniser
    sequence s_low;
        $fell(i_select_n) ##1 !i_select_n [*3];
    endsequence
    property p_oe_idle;
        i_select_n |-> !o_result_line_a_oe && !o_result_line_b_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("line driven while select high");
    property p_abort_pulse;
        o_conversion_aborted |=> !o_conversion_aborted;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("abort longer than one cycle");
    property p_mode_at_rise;
        $changed(o_power_mode) |-> i_select_n && $past(i_select_n);
    endproperty
    a_mode_at_rise: assert property (p_mode_at_rise) else $error("mode moved with select low");
    property p_enter_partial;
        o_power_mode == 2'h1 && $past(o_power_mode) != 2'h1
            |-> $past(o_power_mode) == 2'h0 && o_conversion_aborted;
    endproperty
    a_enter_partial: assert property (p_enter_partial) else $error("bad partial entry");
    property p_enter_full;
        o_power_mode == 2'h2 && $past(o_power_mode) != 2'h2
            |-> $past(o_power_mode) == 2'h1 && o_conversion_aborted;
    endproperty
    a_enter_full: assert property (p_enter_full) else $error("bad full entry");
    property p_partial_idle;
        s_idle ##0 o_power_mode == 2'h1 |-> !o_analog_on && o_reference_on;
    endproperty
    a_partial_idle: assert property (p_partial_idle) else $error("partial power wrong");
    property p_full_idle;
        s_idle ##0 o_power_mode == 2'h2 |-> !o_analog_on && !o_reference_on;
    endproperty
    a_full_idle: assert property (p_full_idle) else $error("full power wrong");
    property p_wake_analog;
        s_low |-> ##[0:2] o_analog_on;
    endproperty
    a_wake_analog: assert property (p_wake_analog) else $error("no power-up on select");
    property p_powered;
        o_powered_up |-> o_power_mode == 2'h0;
    endproperty
    a_powered: assert property (p_powered) else $error("ready outside normal");
endmodule

bind apms_sequencer apms_seq_properties u_props (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_select_n(i_select_n), .o_result_line_a_oe(o_result_line_a_oe),
    .o_result_line_b_oe(o_result_line_b_oe), .o_power_mode(o_power_mode),
    .o_analog_on(o_analog_on), .o_reference_on(o_reference_on),
    .o_powered_up(o_powered_up), .o_conversion_aborted(o_conversion_aborted));

// ===== test/tb.sv
// self-checking bench for the power-mode sequencer
`timescale 1ns/1ps
module tb;
    localparam int WAKE = 200; // shortened full wake count
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic sclk, sel_n, da, da_oe, db, db_oe, analog_on, ref_on, pw_up, abort;
    logic [11:0] res_a = 12'h000;
    logic [11:0] res_b = 12'h000;
    logic [1:0] mode;
    int n_errors = 0;
    int n_tests = 0;
    int seed = 27;
    int n_abort = 0;
    int exp_mode = 0;
    // lengths: reads, aborts, glitches, power-down and wake paths
    int lens[$] = '{16, 32, 33, 14, 13, 10, 1, 2, 1, 9, 5, 12, 10, 5, 11, 0, 3, 2, 10};
    always #12.5 i_clk_sys = ~i_clk_sys;
    // count abort pulses seen on the system side
    always @(posedge i_clk_sys) if (abort === 1'b1) n_abort++;
    apms_sequencer #(.FULL_WAKE_CYC(WAKE)) uut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_converter_serial_clock(sclk), .i_select_n(sel_n), .i_conv_result_a(res_a),
        .i_conv_result_b(res_b), .o_result_line_a(da), .o_result_line_a_oe(da_oe),
        .o_result_line_b(db), .o_result_line_b_oe(db_oe), .o_power_mode(mode),
        .o_analog_on(analog_on), .o_reference_on(ref_on), .o_powered_up(pw_up),
        .o_conversion_aborted(abort));
    apms_host_model host (.o_converter_serial_clock(sclk), .o_select_n(sel_n),
        .i_result_line_a(da), .i_result_line_a_oe(da_oe),
        .i_result_line_b(db), .i_result_line_b_oe(db_oe));
    // single comparison point
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // expected line level after k edges: two zeros, 12 bits, two zeros, other word
    function automatic logic bit_at(input logic [11:0] own, input logic [11:0] oth, input int k);
        int p = k % 16;
        logic [11:0] w = (k < 16) ? own : oth;
        return (p >= 2 && p <= 13) ? w[13 - p] : 1'b0;
    endfunction
    // one frame plus all its checks against the reference model
    task automatic frame(input int n);
        logic [11:0] a, b;
        bit wake;
        @(posedge i_clk_sys);
        a = 12'($random(seed));
        b = 12'($random(seed));
        res_a <= a;
        res_b <= b;
        n_abort = 0;
        #3;
        host.run_frame(n);
        for (int k = 1; k <= n && k <= 33; k++) begin
            check("oe a", host.oe_a[k], 12'(k < 32));
            check("oe b", host.oe_b[k], 12'(k < 32));
            if (k < 32) check("line a", host.dat_a[k], bit_at(a, b, k));
            if (k < 32) check("line b", host.dat_b[k], bit_at(b, a, k));
        end
        wake = exp_mode != 0 && n >= 10;
        if (n >= 2 && n <= 9) exp_mode = (exp_mode == 0) ? 1 : 2;
        else if (n >= 10) exp_mode = 0;
        check("oe after", {da_oe, db_oe}, 12'h000);
        check("mode", mode, 12'(exp_mode));
        check("aborts", 12'(n_abort), 12'(n >= 2 && n <= 13));
        check("analog", analog_on, 12'(exp_mode == 0));
        check("reference", ref_on, 12'(exp_mode != 2));
        check("ready early", pw_up, 12'(exp_mode == 0 && !wake));
        // the wait covers the long wake, so the short one is never relied on
        repeat (wake ? WAKE + 10 : 0) @(posedge i_clk_sys);
        check("ready", pw_up, 12'(exp_mode == 0));
        $display("frame of %0d edges done, mode %0d", n, exp_mode);
    endtask
    // closing verdict
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // main sequence: reset, table of frames, then random lengths
    initial begin
        repeat (3) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        foreach (lens[i]) frame(lens[i]);
        repeat (8) frame($unsigned($random(seed)) % 34);
        final_report();
    end
    // watchdog, well beyond the expected run length
    initial begin
        #500000;
        n_errors++;
        $display("watchdog expired");
        final_report();
    end
endmodule
